// [logic/tvic_pkg.sv]
// Purpose: constants shared by the tv interrupt controller
// Assumes: 32-bit apb data, one register per aligned word
// Notes:   source index order is the polling order, lowest index first
package tvic_pkg;
   localparam int NUM_SRC = 15;
   // apb byte offsets
   localparam logic [7:0] ENABLE_OFS   = 8'h00;
   localparam logic [7:0] PRIORITY_OFS = 8'h04;
   localparam logic [7:0] SENSE_OFS    = 8'h08;
   localparam logic [7:0] TIMERCTL_OFS = 8'h0c;
   localparam logic [7:0] BUSYCFG_OFS  = 8'h10;
   localparam logic [7:0] PENDING_OFS  = 8'h14;
   localparam logic [7:0] CONTROL_OFS  = 8'h18;
   localparam logic [7:0] STATUS_OFS   = 8'h1c;
   localparam logic [7:0] IRQSTAT_OFS  = 8'h20;
   localparam logic [7:0] IRQMASK_OFS  = 8'h24;
   localparam logic [7:0] SLICE_OFS    = 8'h28;
   // field positions
   localparam int GLOBAL_EN_BIT  = 7;
   localparam int BUSY_MODE_BIT  = 0;
   localparam int IDLE_BIT       = 0;
   localparam int RETURN_BIT     = 1;
   // reset values
   localparam logic [15:0] ENABLE_RST = 16'h0000;
   localparam logic [14:0] PRIO_RST   = 15'h0000;
   localparam logic [7:0]  SENSE_RST  = 8'h00;
   // sense encodings for pins 2..5
   localparam logic [1:0] SENSE_LOW  = 2'h0;
   localparam logic [1:0] SENSE_RISE = 2'h1;
   localparam logic [1:0] SENSE_FALL = 2'h2;
   localparam logic [1:0] SENSE_BOTH = 2'h3;
   // source index in polling order
   localparam int SRC_EXT0 = 0;
   localparam int SRC_EXT2 = 5;
   localparam int SRC_EXT1 = 6;
   localparam int SRC_EXT3 = 8;
   localparam int SRC_EXT4 = 11;
   localparam int SRC_CAP  = 12;
   localparam int SRC_EXT5 = 14;
   localparam int SRC_BUSY = 4;
   // vector table, one entry per polling slot
   localparam logic [15:0] VEC [NUM_SRC] = '{
      16'h0003, 16'h002b, 16'h0053, 16'h000b, 16'h0033,
      16'h005b, 16'h0013, 16'h003b, 16'h0063, 16'h001b,
      16'h0043, 16'h006b, 16'h0023, 16'h004b, 16'h0073};
   // enable register bit for each polling slot (int number)
   localparam int ENBIT [NUM_SRC] = '{
      0, 5, 10, 1, 6, 11, 2, 7, 12, 3, 8, 13, 4, 9, 14};
   typedef enum logic [1:0] {SV_NONE, SV_LOW, SV_HIGH} tvic_level_t;
endpackage

// [logic/tvic_top.sv]
// Purpose: 15-source two-level interrupt controller with vector calls
// Assumes: core pulses vecTaken when it launches the long call, retDone
//          on return from service; pins come from outside the clock
// Notes:   enables and priorities stored in interrupt-number order
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
module tvic_top
   import tvic_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // external pins 0..5
   input  wire logic [5:0]  extPinIn,
   // internal sources, one-cycle pulses
   input  wire logic        timerAIrq,
   input  wire logic        timerBIrq,
   input  wire logic        timerCIrq,
   input  wire logic        serialBusIrq,
   input  wire logic        uartRxIrq,
   input  wire logic        uartTxIrq,
   input  wire logic        uartCombinedIrq,
   // display and caption events
   input  wire logic        captionMode,
   input  wire logic        sliceLineEnd,
   input  wire logic        hBlankStart,
   input  wire logic        vBlankStart,
   // core vectoring
   output logic             callReq,
   output logic [15:0]      callVector,
   input  wire logic        vecTaken,
   input  wire logic        retDone,
   output logic             idleActive,
   output logic             irqOut
);
   import tvic_pkg::*;

   logic [15:0] enable_r;      // bit 7 global and also int 7, others per int number
   logic [14:0] prio_r;        // 1 = high level, int-number order
   logic [7:0]  sense_r;       // two bits per pin 2..5
   logic [1:0]  trig_r;        // pin0/pin1 trigger select
   logic        busyMode_r;    // 1 = field mode
   logic [7:0]  slice_r;
   logic        idle_r;
   logic [NUM_SRC-1:0] latch_r; // latched requests, polling order
   logic [NUM_SRC-1:0] levelReq;
   logic [NUM_SRC-1:0] setReq;
   logic [NUM_SRC-1:0] pend;
   logic [NUM_SRC-1:0] eligHi;
   logic [NUM_SRC-1:0] eligLo;
   logic [NUM_SRC-1:0] clrMask;
   logic [5:0]  pinS1_r;
   logic [5:0]  pinS2_r;
   logic [5:0]  pinD_r;
   logic [5:0]  rise;
   logic [5:0]  fall;
   logic        lowAct_r;
   logic        highAct_r;
   logic [1:0]  irqStat_r;     // 0 call taken, 1 idle wake
   logic [1:0]  irqMask_r;
   logic [3:0]  selIdx;
   logic [3:0]  callIdx_r;     // slot whose vector stands on callVector
   logic        selValid;
   logic        selHigh;
   logic        wrEn;
   logic        rdEn;
   logic [31:0] rdData;

   // first-found index in polling order, used for both levels
   function automatic logic [4:0] pickFirst(input logic [NUM_SRC-1:0] v);
      logic [4:0] r;
      r = 5'h1f;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 5'(i);
         end
      end
      return r;
   endfunction

   // pin synchroniser; stage one is read only by stage two
   always_ff @(posedge ref_clk) begin
      pinS1_r <= extPinIn;
      pinS2_r <= pinS1_r;
      pinD_r  <= pinS2_r;
   end

   assign rise = pinS2_r & ~pinD_r;
   assign fall = ~pinS2_r & pinD_r;

   // sense decoding into per-source set pulses and level requests
   function automatic logic pinEdge(input logic [1:0] s, input logic r,
                                    input logic f);
      case (s)
         SENSE_RISE: pinEdge = r;
         SENSE_FALL: pinEdge = f;
         SENSE_BOTH: pinEdge = r | f;
         default:    pinEdge = 1'b0;
      endcase
   endfunction

   always_comb begin
      setReq   = '0;
      levelReq = '0;
      // pins 0 and 1: level low or transition
      if (trig_r[0]) setReq[SRC_EXT0] = fall[0];
      else levelReq[SRC_EXT0] = ~pinS2_r[0];
      if (trig_r[1]) setReq[SRC_EXT1] = rise[1] | fall[1];
      else levelReq[SRC_EXT1] = ~pinS2_r[1];
      // pins 2..5
      setReq[SRC_EXT2] = pinEdge(sense_r[1:0], rise[2], fall[2]);
      setReq[SRC_EXT3] = pinEdge(sense_r[3:2], rise[3], fall[3]);
      setReq[SRC_EXT4] = pinEdge(sense_r[5:4], rise[4], fall[4]);
      setReq[SRC_EXT5] = pinEdge(sense_r[7:6], rise[5], fall[5]);
      levelReq[SRC_EXT2] = (sense_r[1:0] == SENSE_LOW) & ~pinS2_r[2];
      levelReq[SRC_EXT3] = (sense_r[3:2] == SENSE_LOW) & ~pinS2_r[3];
      levelReq[SRC_EXT4] = (sense_r[5:4] == SENSE_LOW) & ~pinS2_r[4];
      levelReq[SRC_EXT5] = (sense_r[7:6] == SENSE_LOW) & ~pinS2_r[5];
      // internal sources
      setReq[1]  = serialBusIrq;
      setReq[2]  = uartRxIrq;
      setReq[3]  = timerAIrq;
      setReq[7]  = timerCIrq;
      setReq[9]  = timerBIrq;
      setReq[10] = uartCombinedIrq;
      setReq[13] = uartTxIrq;
      setReq[SRC_CAP]  = captionMode & sliceLineEnd;
      setReq[SRC_BUSY] = busyMode_r ? vBlankStart
                                    : hBlankStart;
   end

   // per-slot eligibility through enables and priorities
   generate
      for (genvar g = 0; g < NUM_SRC; g++) begin : gSlot
         assign pend[g] = (latch_r[g] | levelReq[g])
                          & enable_r[ENBIT[g]]
                          & enable_r[GLOBAL_EN_BIT];
         assign eligHi[g] = pend[g] & prio_r[ENBIT[g]];
         assign eligLo[g] = pend[g] & ~prio_r[ENBIT[g]];
      end
   endgenerate

   // arbitration: high before low, polling order inside a level
   always_comb begin
      logic [4:0] hi;
      logic [4:0] lo;
      hi = pickFirst(eligHi);
      lo = pickFirst(eligLo);
      selValid = 1'b0;
      selHigh  = 1'b0;
      selIdx   = '0;
      if (!highAct_r && hi != 5'h1f) begin
         selValid = 1'b1;
         selHigh  = 1'b1;
         selIdx   = hi[3:0];
      end else if (!highAct_r && !lowAct_r && lo != 5'h1f) begin
         selValid = 1'b1;
         selIdx   = lo[3:0];
      end
   end

   // edge requests latch; set wins over clear on taken call
   always_comb begin
      clrMask = '0;
      if (vecTaken && callReq) begin
         // clear the slot the core took, not a newer winner
         clrMask[callIdx_r] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) latch_r <= '0;
      else latch_r <= (latch_r & ~clrMask) | setReq;
   end

   // call request toward the core, registered
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         callReq    <= 1'b0;
         callVector <= 16'h0000;
         callIdx_r  <= 4'h0;
      end else if (vecTaken && callReq) begin
         callReq    <= 1'b0;
      end else begin
         callReq    <= selValid;
         callVector <= VEC[selIdx];
         callIdx_r  <= selIdx;
      end
   end

   // active service levels; return ends the highest active one
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         lowAct_r  <= 1'b0;
         highAct_r <= 1'b0;
      end else if (vecTaken && callReq) begin
         if (prio_r[ENBIT[callIdx_r]]) highAct_r <= 1'b1;
         else lowAct_r <= 1'b1;
      end else if (retDone) begin
         if (highAct_r) highAct_r <= 1'b0;
         else lowAct_r <= 1'b0;
      end
   end

   // apb decode, zero wait states
   assign wrEn = psel & penable & pwrite;
   assign rdEn = psel & ~penable & ~pwrite;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         enable_r   <= ENABLE_RST;
         prio_r     <= PRIO_RST;
         sense_r    <= SENSE_RST;
         trig_r     <= 2'h0;
         busyMode_r <= 1'b0;
         slice_r    <= 8'h00;
         irqMask_r  <= 2'h0;
      end else if (wrEn) begin
         case (paddr)
            ENABLE_OFS:   enable_r   <= pwdata[15:0];
            PRIORITY_OFS: prio_r     <= pwdata[14:0];
            SENSE_OFS:    sense_r    <= pwdata[7:0];
            TIMERCTL_OFS: trig_r     <= pwdata[1:0];
            BUSYCFG_OFS:  busyMode_r <= pwdata[BUSY_MODE_BIT];
            SLICE_OFS:    slice_r    <= pwdata[7:0];
            IRQMASK_OFS:  irqMask_r  <= pwdata[1:0];
            default:      ;
         endcase
      end
   end

   // idle bit: software sets, a request that wins arbitration (selValid) clears it
   always_ff @(posedge ref_clk) begin
      if (reset) idle_r <= 1'b0;
      else if (selValid) idle_r <= 1'b0;
      else if (wrEn && paddr == CONTROL_OFS && pwdata[IDLE_BIT])
         idle_r <= 1'b1;
   end

   // sticky status, write one to clear; new event beats clear
   always_ff @(posedge ref_clk) begin
      if (reset) irqStat_r <= 2'h0;
      else irqStat_r <= (irqStat_r
                         & ~((wrEn && paddr == IRQSTAT_OFS) ?
                             pwdata[1:0] : 2'h0))
                        | {idle_r & selValid, vecTaken & callReq};
   end

   always_ff @(posedge ref_clk) begin
      if (reset) irqOut <= 1'b0;
      else irqOut <= |(irqStat_r & irqMask_r);
   end

   always_ff @(posedge ref_clk) begin
      if (reset) idleActive <= 1'b0;
      else idleActive <= idle_r;
   end

   // read mux
   always_comb begin
      case (paddr)
         ENABLE_OFS:   rdData = {16'h0000, enable_r};
         PRIORITY_OFS: rdData = {17'h00000, prio_r};
         SENSE_OFS:    rdData = {24'h000000, sense_r};
         TIMERCTL_OFS: rdData = {30'h00000000, trig_r};
         BUSYCFG_OFS:  rdData = {31'h00000000, busyMode_r};
         PENDING_OFS:  rdData = {17'h00000, pend};
         CONTROL_OFS:  rdData = {31'h00000000, idle_r};
         STATUS_OFS:   rdData = {27'h0000000, highAct_r, lowAct_r,
                                 selValid, callReq, idle_r};
         IRQSTAT_OFS:  rdData = {30'h00000000, irqStat_r};
         IRQMASK_OFS:  rdData = {30'h00000000, irqMask_r};
         SLICE_OFS:    rdData = {24'h000000, slice_r};
         default:      rdData = 32'h00000000;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         if (rdEn) prdata <= rdData;
      end
   end
endmodule

// [verification/tvic_core_model.sv]
// Purpose: core sequencer model that takes vector calls and returns
// Assumes: call accepted at the edge where vecTaken meets callReq
// Notes:   ackDly stretches the acceptance to exercise a slow core
`timescale 1ns/1ps
module tvic_core_model (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // vectoring
   input  wire logic        callReq,
   input  wire logic [15:0] callVector,
   output logic             vecTaken,
   output logic             retDone,
   // bench control
   input  wire logic [3:0]  ackDly,
   input  wire logic        doRet,
   output logic [15:0]      lastVec,
   output logic [7:0]       takenCnt
);
   logic [3:0] waitCnt_r;
   // take the call after ackDly cycles, record vector at acceptance
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         vecTaken  <= 1'b0;
         retDone   <= 1'b0;
         waitCnt_r <= 4'h0;
         lastVec   <= 16'h0000;
         takenCnt  <= 8'h00;
      end else begin
         retDone  <= doRet;
         vecTaken <= 1'b0;
         if (callReq && vecTaken) begin
            lastVec  <= callVector;
            takenCnt <= takenCnt + 8'h01;
         end else if (callReq && waitCnt_r >= ackDly) begin
            vecTaken  <= 1'b1;
            waitCnt_r <= 4'h0;
         end else if (callReq) begin
            waitCnt_r <= waitCnt_r + 4'h1;
         end
      end
   end
endmodule

// [verification/tvic_chk.sv]
// Purpose: port assertions for the tv interrupt controller
// Assumes: apb writes take effect at the pready edge
// Notes:   shadows enable and priority to qualify the latency checks
`timescale 1ns/1ps
module tvic_chk
   import tvic_pkg::*;
(
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        reset,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   // sources and core
   input wire logic        timerAIrq,
   input wire logic        serialBusIrq,
   input wire logic        callReq,
   input wire logic [15:0] callVector,
   input wire logic        vecTaken,
   input wire logic        retDone,
   input wire logic        idleActive
);
   logic [15:0] enReg_r;
   logic [15:0] prio_r;
   logic [1:0]  depth_r;
   logic        wr;
   logic        rdy;
   assign wr = psel && penable && pready && pwrite;
   // latency checks only hold with all on and nothing in service
   assign rdy = enReg_r == 16'hffff && depth_r == 2'd0 && !callReq;
   // shadow registers follow the bus writes
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         enReg_r <= ENABLE_RST;
         prio_r  <= 16'h0000;
      end else if (wr && paddr == ENABLE_OFS) begin
         enReg_r <= pwdata[15:0];
      end else if (wr && paddr == PRIORITY_OFS) begin
         prio_r <= pwdata[15:0];
      end
   end
   // nesting depth from accepted calls and returns
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         depth_r <= 2'd0;
      end else if (callReq && vecTaken && !retDone) begin
         depth_r <= depth_r + 2'd1;
      end else if (retDone && !vecTaken && depth_r != 2'd0) begin
         depth_r <= depth_r - 2'd1;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   AST_GLOBAL: assert property ($rose(callReq) |-> enReg_r[7])
      else $error("call raised with global enable off");
   AST_VECTOR: assert property (callReq |-> callVector[2:0] == 3'h3
      && callVector[15:7] == 9'h000) else $error("illegal vector");
   AST_HOLD: assert property (callReq && !vecTaken |=> callReq)
      else $error("call dropped before acceptance");
   AST_RELEASE: assert property (callReq && vecTaken |=> !callReq)
      else $error("call held after acceptance");
   AST_NEST: assert property (depth_r == 2'd2 |-> !callReq)
      else $error("call raised during high service");
   AST_WAKE: assert property ($rose(callReq) |-> ##[0:2] !idleActive)
      else $error("idle not ended by request");
   AST_TIMER: assert property (timerAIrq && rdy |-> ##2 callReq)
      else $error("timer request not called in time");
   AST_SERIAL: assert property (serialBusIrq && rdy |-> ##2 callReq)
      else $error("serial request not called in time");
   AST_LEVEL: assert property (timerAIrq && serialBusIrq && rdy
      && prio_r[1] |-> ##2 callVector == 16'h000b)
      else $error("higher level lost the contest");
   AST_POLL: assert property (timerAIrq && serialBusIrq && rdy
      && !prio_r[1] |-> ##2 callVector == 16'h002b)
      else $error("polling order broken");
   cover property (depth_r == 2'd2);
   cover property ($fell(idleActive));
   cover property (callReq && callVector == 16'h0033);
endmodule
bind tvic_top tvic_chk tvic_chk_inst (
   .ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .timerAIrq, .serialBusIrq, .callReq, .callVector, .vecTaken,
   .retDone, .idleActive);

// [verification/tb_top.sv]
// Purpose: self-checking bench for the tv interrupt controller
// Assumes: core model accepts calls; bench ends each service
// Notes:   single-source table first, nesting and pin modes after
`timescale 1ns/1ps
module tb_top;
   import tvic_pkg::*;
   logic        ref_clk, reset, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, takenCnt;
   logic [31:0] pwdata, prdata, q;
   logic [5:0]  extPinIn;
   logic [9:0]  src;
   logic        timerAIrq, timerBIrq, timerCIrq, serialBusIrq, uartRxIrq;
   logic        uartTxIrq, uartCombinedIrq, captionMode, sliceLineEnd;
   logic        hBlankStart, vBlankStart, callReq, vecTaken, retDone;
   logic        idleActive, irqOut, doRet;
   logic [15:0] callVector, lastVec;
   logic [3:0]  ackDly;
   logic [25:0] rows [9];
   int          bad_count, checks;
   assign {vBlankStart, hBlankStart, sliceLineEnd, uartCombinedIrq,
      uartTxIrq, uartRxIrq, serialBusIrq, timerCIrq, timerBIrq,
      timerAIrq} = src;
   tvic_top tvic_top_inst (.ref_clk, .reset, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .extPinIn, .timerAIrq,
      .timerBIrq, .timerCIrq, .serialBusIrq, .uartRxIrq, .uartTxIrq,
      .uartCombinedIrq, .captionMode, .sliceLineEnd, .hBlankStart,
      .vBlankStart, .callReq, .callVector, .vecTaken, .retDone,
      .idleActive, .irqOut);
   tvic_core_model tvic_core_model_inst (.ref_clk, .reset, .callReq,
      .callVector, .vecTaken, .retDone, .ackDly, .doRet, .lastVec,
      .takenCnt);
   // 250 mhz clock
   always #2 ref_clk = ~ref_clk;
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         bad_count++;
         $display("wrong value t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // apb transfer; waits on pready, never on a fixed count
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) bad_count++;
      q = prdata;
      {psel, penable} <= 2'b00;
   endtask
   task automatic pulse(input logic [9:0] v);
      @(posedge ref_clk);
      src <= v;
      @(posedge ref_clk);
      src <= 10'h000;
   endtask
   // wait for an accepted call and compare its vector
   task automatic call(input logic [15:0] v);
      int n;
      logic [7:0] c;
      n = 0;
      c = takenCnt;
      while (takenCnt === c && n < 60) begin
         @(posedge ref_clk);
         n++;
      end
      chk(lastVec, v);
   endtask
   task automatic ret();
      @(posedge ref_clk);
      doRet <= 1'b1;
      @(posedge ref_clk);
      doRet <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic none(input int n);
      logic [7:0] c;
      c = takenCnt;
      repeat (n) @(posedge ref_clk);
      chk(takenCnt, c);
   endtask
   task automatic results();
      $display("mismatches %0d of %0d compares", bad_count, checks);
      if (bad_count == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // watchdog, far beyond the few hundred cycles the run needs
   initial begin
      #100000;
      bad_count++;
      results();
   end
   initial begin
      rows = '{{10'h001, 16'h000b}, {10'h002, 16'h001b},
         {10'h004, 16'h003b}, {10'h008, 16'h002b}, {10'h010, 16'h0053},
         {10'h020, 16'h004b}, {10'h040, 16'h0043}, {10'h080, 16'h0023},
         {10'h100, 16'h0033}};
      {ref_clk, reset, psel, penable, pwrite, doRet} = 6'b010000;
      {paddr, pwdata, src, ackDly} = '0;
      {extPinIn, captionMode} = 7'h7f;
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      chk({callReq, irqOut, idleActive}, 3'b000);
      apb(0, ENABLE_OFS, 0); chk(q, ENABLE_RST);
      apb(0, PRIORITY_OFS, 0); chk(q, PRIO_RST);
      apb(0, 8'h30, 0); chk(q, 0);
      chk(pslverr, 0);
      apb(1, ENABLE_OFS, 32'hffff);
      foreach (rows[i]) begin
         ackDly <= 4'(3 * (i % 2));
         pulse(rows[i][25:16]);
         call(rows[i][15:0]);
         ret();
      end
      apb(1, BUSYCFG_OFS, 1);
      pulse(10'h100); none(10);
      pulse(10'h200); call(16'h0033); ret();
      captionMode <= 1'b0;
      pulse(10'h080); none(10);
      apb(1, ENABLE_OFS, 32'hff7f);
      extPinIn <= 6'h3e; none(10);
      extPinIn <= 6'h3f;
      apb(1, ENABLE_OFS, 32'hffff);
      extPinIn <= 6'h3e; call(16'h0003);
      extPinIn <= 6'h3f; ret(); none(10);
      apb(1, TIMERCTL_OFS, 2);
      extPinIn <= 6'h3d; call(16'h0013); ret();
      extPinIn <= 6'h3f; call(16'h0013); ret(); none(10);
      apb(1, SENSE_OFS, 1);
      extPinIn <= 6'h3b; none(10);
      extPinIn <= 6'h3f; call(16'h005b); ret(); none(10);
      pulse(10'h009); call(16'h002b);
      apb(1, PRIORITY_OFS, 2);
      call(16'h000b);
      pulse(10'h010); none(10);
      ret(); ret(); call(16'h0053); ret();
      pulse(10'h009); call(16'h000b); ret();
      call(16'h002b); ret();
      apb(1, CONTROL_OFS, 1); repeat (2) @(posedge ref_clk);
      chk(idleActive, 1);
      pulse(10'h002); call(16'h001b); chk(idleActive, 0); ret();
      apb(1, IRQMASK_OFS, 1); repeat (2) @(posedge ref_clk);
      chk(irqOut, 1);
      apb(1, IRQSTAT_OFS, 1); repeat (2) @(posedge ref_clk);
      chk(irqOut, 0);
      results();
   end
endmodule
